// *** rtl/grayscale_shift_latch_port.sv ***
// serial load path, grayscale latch and channel gating of a sink driver
`timescale 1ns/1ps
`default_nettype none
`include "gs_port_params.svh"
module grayscale_shift_latch_port
#(
  parameter int CHANNELS = `GSP_CHANNELS,
  parameter int GS_BITS  = `GSP_GS_BITS
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // serial link from the host or the upstream device
  input  wire logic                shiftClk,
  input  wire logic                serialDataIn,
  input  wire logic                latchStrobe,
  output logic                     cascadeDataOut,
  // display control
  input  wire logic                blank,
  // channel sinks, bit 0 first channel, top bit last channel
  output logic [CHANNELS-1:0]      channelSinkLine
);
  localparam int FRAME = CHANNELS * GS_BITS;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  gs_port_pkg::link_pins_t sync1Reg;
  gs_port_pkg::link_pins_t sync2Reg;
  logic                    shiftClkPrevReg;
  logic                    latchPrevReg;
  wire                     shiftClkSync = sync2Reg[3];
  wire                     serialSync   = sync2Reg[2];
  wire                     latchSync    = sync2Reg[1];
  wire                     blankSync    = sync2Reg[0];
  wire                     shiftRise    = shiftClkSync & ~shiftClkPrevReg;
  wire                     shiftFall    = ~shiftClkSync & shiftClkPrevReg;
  wire                     latchRise    = latchSync & ~latchPrevReg;

  // every pin passes two flops; edges are found after the second
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1Reg        <= `GSP_SYNC_RST;
      sync2Reg        <= `GSP_SYNC_RST;
      shiftClkPrevReg <= 1'b0;
      latchPrevReg    <= 1'b0;
    end
    else
    begin
      sync1Reg        <= {shiftClk, serialDataIn, latchStrobe, blank};
      sync2Reg        <= sync1Reg;
      shiftClkPrevReg <= shiftClkSync;
      latchPrevReg    <= latchSync;
    end
  end

  // ----------------------------------------------------------------------
  // shift register and cascade stage
  // ----------------------------------------------------------------------
  logic [FRAME-1:0] shiftReg;
  logic             cascadeReg;

  // data and clock share the sync depth, so they stay aligned
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      shiftReg <= '0;
    else if (shiftRise)
      shiftReg <= {shiftReg[FRAME-2:0], serialSync};
  end

  // launching on the fall gives the next device half a period of margin
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cascadeReg <= 1'b0;
    else if (shiftFall)
      cascadeReg <= shiftReg[FRAME-1];
  end

  assign cascadeDataOut = cascadeReg;

  // ----------------------------------------------------------------------
  // strobe to latch through the frame buffer
  // ----------------------------------------------------------------------
  logic [FRAME-1:0]       gsLatchReg;
  logic                   loadPendReg;
  logic [GS_BITS-1:0]     pwmCntReg;
  wire  [FRAME-1:0]       bufOut;
  wire                    bufOutValid;
  wire                    bufInReady;
  wire                    pushValid = latchRise | loadPendReg;
  wire                    wrapCycle = (pwmCntReg == '1);
  // no latch update on the wrap cycle; a strobe one cycle before it leaves count 0 lit from the old frame
  wire                    popReady  = ~wrapCycle;
  wire                    popFire   = bufOutValid & popReady;

  frame_buffer
  #(
    .WIDTH (FRAME),
    .DEPTH (`GSP_BUF_DEPTH)
  )
  u_frame_buffer
  (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inData   (shiftReg),
    .inValid  (pushValid),
    .inReady  (bufInReady),
    .outData  (bufOut),
    .outValid (bufOutValid),
    .outReady (popReady)
  );

  // a strobe met by a full buffer waits here instead of being lost;
  // the host's 100 ns quiet time keeps the frame steady meanwhile
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      loadPendReg <= 1'b0;
    else
      loadPendReg <= pushValid & ~bufInReady;
  end

  // grayscale latch
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      gsLatchReg <= '0;
    else if (popFire)
      gsLatchReg <= bufOut;
  end

  // ----------------------------------------------------------------------
  // PWM timing, hold-off and channel gating
  // ----------------------------------------------------------------------
  logic                holdOffReg;
  wire  [CHANNELS-1:0] chOn;

  // strobe leaves the count alone; only blank clears it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pwmCntReg <= `GSP_CNT_RST;
    else if (blankSync)
      pwmCntReg <= '0;
    else
      pwmCntReg <= pwmCntReg + 1'b1;
  end

  // a strobe in the wrap cycle still wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      holdOffReg <= 1'b0;
    else if (latchRise)
      holdOffReg <= 1'b1;
    else if (wrapCycle | blankSync)
      holdOffReg <= 1'b0;
  end

  // one comparator per channel against its twelve-bit field
  generate
    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_chan
      assign chOn[i] = (pwmCntReg < gsLatchReg[i*GS_BITS +: GS_BITS])
                       & ~holdOffReg & ~blankSync;
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      channelSinkLine <= '0;
    else
      channelSinkLine <= chOn;
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_strobe_rise;
    latchRise;
  endsequence

  sequence s_outputs_dark;
    holdOffReg ##1 (channelSinkLine == '0);
  endsequence

  property p_shift_in;
    @(posedge clk_sys) disable iff (!rst_n)
    shiftRise |=> shiftReg[0] == $past(serialSync);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial bit not captured at bottom");

  property p_shift_move;
    @(posedge clk_sys) disable iff (!rst_n)
    shiftRise |=> shiftReg[FRAME-1:1] == $past(shiftReg[FRAME-2:0]);
  endproperty
  a_shift_move: assert property (p_shift_move)
    else $error("shift register did not move by one");

  property p_cascade_fall;
    @(posedge clk_sys) disable iff (!rst_n)
    shiftFall |=> cascadeDataOut == $past(shiftReg[FRAME-1]);
  endproperty
  a_cascade_fall: assert property (p_cascade_fall)
    else $error("cascade output not MSB after fall");

  property p_cascade_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !shiftFall |=> $stable(cascadeDataOut);
  endproperty
  a_cascade_hold: assert property (p_cascade_hold)
    else $error("cascade output moved without a fall");

  property p_latch_copy;
    @(posedge clk_sys) disable iff (!rst_n)
    // the pop comes one cycle after the push, so test the wrap there
    (s_strobe_rise and !bufOutValid) ##1 !wrapCycle |=>
      gsLatchReg == $past(shiftReg, 2);
  endproperty
  a_latch_copy: assert property (p_latch_copy)
    else $error("latch does not hold the strobed frame");

  property p_hold_off;
    @(posedge clk_sys) disable iff (!rst_n)
    s_strobe_rise |=> s_outputs_dark;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("outputs not forced off after strobe");

  property p_cnt_kept;
    @(posedge clk_sys) disable iff (!rst_n)
    (latchRise && !blankSync) |=> pwmCntReg == $past(pwmCntReg) + 1'b1;
  endproperty
  a_cnt_kept: assert property (p_cnt_kept)
    else $error("strobe disturbed the PWM counter");

  property p_blank;
    @(posedge clk_sys) disable iff (!rst_n)
    blankSync |=> (pwmCntReg == '0) && (channelSinkLine == '0);
  endproperty
  a_blank: assert property (p_blank)
    else $error("blank did not clear counter and outputs");

  property p_pwm_step;
    @(posedge clk_sys) disable iff (!rst_n)
    (!holdOffReg && !blankSync) |=>
      channelSinkLine[0] == $past(pwmCntReg < gsLatchReg[GS_BITS-1:0]);
  endproperty
  a_pwm_step: assert property (p_pwm_step)
    else $error("channel on-time does not match its value");
endmodule // grayscale_shift_latch_port
`default_nettype wire

// *** rtl/gs_port_params.svh ***
// timing counts, widths and reset values of the grayscale shift/latch port
`ifndef GS_PORT_PARAMS_SVH
`define GS_PORT_PARAMS_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define GSP_CHANNELS        24
`define GSP_GS_BITS         12
`define GSP_BUF_DEPTH       2

// ----------------------------------------------------------------------
// clock and link timing
// ----------------------------------------------------------------------
`define GSP_CLK_PERIOD_NS   10
`define GSP_T_LATCH_SHIFT_NS 100
`define GSP_T_LATCH_SHIFT_CYC \
  ((`GSP_T_LATCH_SHIFT_NS + `GSP_CLK_PERIOD_NS - 1) / `GSP_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GSP_SYNC_RST        4'h0
`define GSP_CNT_RST         12'h000

`endif

// *** rtl/gs_port_pkg.sv ***
// shared types of the grayscale shift/latch port
package gs_port_pkg;
  typedef logic [11:0] grayscale_t;
  typedef logic [3:0]  link_pins_t;
endpackage

// *** rtl/frame_buffer.sv ***
// small valid/ready buffer that carries latched frames to the display side
`timescale 1ns/1ps
`default_nettype none
module frame_buffer
#(
  parameter int WIDTH = 288,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // filling side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // draining side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] memArr [DEPTH];
  logic [PW-1:0]    wrPtrReg;
  logic [PW-1:0]    rdPtrReg;
  logic [PW:0]      cntReg;
  wire              push = inValid & inReady;
  wire              pop  = outValid & outReady;
  wire  [PW-1:0]    wrPtrNext;
  wire  [PW-1:0]    rdPtrNext;

  // ----------------------------------------------------------------------
  // flags and pointer wrap
  // ----------------------------------------------------------------------
  assign inReady   = (cntReg != (PW+1)'(DEPTH));
  assign outValid  = (cntReg != '0);
  assign outData   = memArr[rdPtrReg];
  assign wrPtrNext = (wrPtrReg == PW'(DEPTH-1)) ? '0 : wrPtrReg + 1'b1;
  assign rdPtrNext = (rdPtrReg == PW'(DEPTH-1)) ? '0 : rdPtrReg + 1'b1;

  // storage has no reset; the count guards every read
  always_ff @(posedge clk_sys)
  begin
    if (push)
      memArr[wrPtrReg] <= inData;
  end

  // pointers and fill count
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      cntReg   <= '0;
    end
    else
    begin
      if (push)
        wrPtrReg <= wrPtrNext;
      if (pop)
        rdPtrReg <= rdPtrNext;
      cntReg <= cntReg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // frame_buffer
`default_nettype wire

// *** verification/gs_host_model.sv ***
// host model that drives the serial link and the latch strobe
`timescale 1ns/1ps
`default_nettype none
module gs_host_model
(
  // link pins toward the device
  output logic      shiftClk,
  output logic      serialDataIn,
  output logic      latchStrobe,
  // cascade pin seen back from the device
  input  wire logic cascadeDataOut
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // idle link: clock stands low outside frames
  initial
  begin
    shiftClk     = 1'b0;
    serialDataIn = 1'b0;
    latchStrobe  = 1'b0;
  end

  // one 125 ns bit cell, cascade sampled just before each edge
  task automatic send_bit(input logic b, output logic preRise,
                          output logic preFall);
    serialDataIn = b;
    #62.5;
    preRise  = cascadeDataOut;
    shiftClk = 1'b1;
    // past the sampling window: inverse level so a late sample is caught
    #31.25;
    serialDataIn = ~b;
    #31.15;
    preFall  = cascadeDataOut;
    #0.1;
    shiftClk = 1'b0;
  endtask

  // strobe pulse, then a quiet gap before any further shifting
  task automatic strobe();
    latchStrobe = 1'b1;
    #50;
    latchStrobe = 1'b0;
    #100;
  endtask
endmodule // gs_host_model
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench of the grayscale shift/latch port
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        blank   = 1'b1;
  wire         shiftClk;
  wire         serialDataIn;
  wire         latchStrobe;
  wire         cascadeDataOut;
  wire  [23:0] channelSinkLine;
  int          mismatches  = 0;
  int          totalChecks = 0;
  int          cyc         = 0;
  int          t0          = 0;
  logic [287:0] f1;
  logic [287:0] f2;

  // clock and free cycle count for tracking the pwm phase
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // device and host
  // ----------------------------------------------------------------
  grayscale_shift_latch_port dut_u
  (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .shiftClk       (shiftClk),
    .serialDataIn   (serialDataIn),
    .latchStrobe    (latchStrobe),
    .cascadeDataOut (cascadeDataOut),
    .blank          (blank),
    .channelSinkLine(channelSinkLine)
  );
  gs_host_model host_u
  (
    .shiftClk      (shiftClk),
    .serialDataIn  (serialDataIn),
    .latchStrobe   (latchStrobe),
    .cascadeDataOut(cascadeDataOut)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] want,
                       input string msg);
    totalChecks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("Error at %0t: %s seen %h want %h", $time, msg, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // inputs move 1 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // field i of a frame holds base + step * i
  function automatic logic [287:0] mk(input int base, input int step);
    logic [287:0] f;
    for (int i = 0; i < 24; i++)
      f[12*i+:12] = 12'(base + step * i);
    return f;
  endfunction

  // channels expected on at a given counter value
  function automatic logic [23:0] lit(input logic [287:0] f, input int c);
    logic [23:0] r;
    for (int i = 0; i < 24; i++)
      r[i] = (f[12*i+:12] > 12'(c));
    return r;
  endfunction

  // first bit sent is the top bit; old contents must leave in order
  task automatic send_frame(input logic [287:0] f,
                            input logic [287:0] prev);
    logic r;
    logic fl;
    for (int k = 287; k >= 0; k--)
    begin
      host_u.send_bit(f[k], r, fl);
      check(24'(r), 24'(prev[k]), "cascade before rise");
      check(24'(fl), 24'(prev[k]), "cascade over high");
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    tick(2);
    check(channelSinkLine, 24'h000000, "sinks in reset");
    check(24'(cascadeDataOut), 24'h000000, "cascade in reset");
  endtask

  // load under blank, then release and compare pwm widths
  task automatic test_load();
    send_frame(f1, '0);
    host_u.strobe();
    tick(3);
    blank = 1'b0;
    t0 = cyc;
    tick(1000);
    check(channelSinkLine, lit(f1, 997), "first frame widths");
  endtask

  // relatch mid-period: dark until wrap, counter keeps running
  task automatic test_relatch();
    int w;
    send_frame(f2, f1);
    for (w = 0; w < 5000 && ((cyc - t0) % 4096) != 1000; w++)
      tick(1);
    if (w == 5000)
    begin
      check(24'h000001, 24'h000000, "phase wait timed out");
      complete_run();
    end
    host_u.strobe();
    tick(5);
    check(channelSinkLine, 24'h000000, "dark after strobe");
    tick(2880);
    check(channelSinkLine, 24'h000000, "dark before wrap");
    tick(240);
    check(channelSinkLine, lit(f2, 41), "lit after wrap");
    tick(700);
    check(channelSinkLine, lit(f2, 741), "second frame widths");
  endtask

  // blank forces dark and restarts the counter from zero
  task automatic test_blank();
    blank = 1'b1;
    tick(6);
    check(channelSinkLine, 24'h000000, "dark under blank");
    blank = 1'b0;
    tick(10);
    check(channelSinkLine, lit(f2, 7), "restart at zero");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    f1 = mk(50, 170);
    f2 = mk(4095, -150);
    test_reset();
    tick(2);
    rst_n = 1'b1;
    tick(4);
    test_load();
    test_relatch();
    test_blank();
    complete_run();
  end
endmodule // tb
`default_nettype wire
